/* include/frt_pkg.sv */
package frt_pkg;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL1 = 8'h00;
   localparam logic [7:0] OFF_CTRL2 = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_CNT_HI = 8'h0C;
   localparam logic [7:0] OFF_CNT_LO = 8'h10;
   localparam logic [7:0] OFF_SHD_HI = 8'h14;
   localparam logic [7:0] OFF_SHD_LO = 8'h18;
   localparam logic [7:0] OFF_CAP1_HI = 8'h1C;
   localparam logic [7:0] OFF_CAP1_LO = 8'h20;
   localparam logic [7:0] OFF_CAP2_HI = 8'h24;
   localparam logic [7:0] OFF_CAP2_LO = 8'h28;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int C1_EDGE1 = 0;
   localparam int C1_ROLL_IE = 1;
   localparam int C1_CAP_IE = 2;
   localparam int C2_SRC = 0;
   localparam int C2_EXT_EDGE = 2;
   localparam int C2_EDGE2 = 3;
   localparam int C2_OPM = 4;
   localparam int C2_PWM = 5;
   localparam int ST_CAP1 = 0;
   localparam int ST_CAP2 = 1;
   localparam int ST_ROLL = 2;

   // ----------------------------------------
   // Reset values and encodings
   // ----------------------------------------
   localparam logic [15:0] CNT_RESET = 16'hFFFC;
   localparam logic [15:0] CNT_TOP = 16'hFFFF;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] SRC_DIV2 = 2'h0;
   localparam logic [1:0] SRC_DIV4 = 2'h1;
   localparam logic [1:0] SRC_DIV8 = 2'h2;
   localparam logic [1:0] SRC_EXT = 2'h3;
   localparam logic [2:0] MASK_DIV2 = 3'h1;
   localparam logic [2:0] MASK_DIV4 = 3'h3;
   localparam logic [2:0] MASK_DIV8 = 3'h7;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CPU_PERIOD_NS = 100;
   localparam int PERIOD_DIV2 = 131072;
   localparam int PERIOD_DIV4 = 262144;
   localparam int PERIOD_DIV8 = 524288;
   localparam int EXT_MIN_GAP = 4;

endpackage : frt_pkg

/* hdl/frt_prescale.sv */
`timescale 1ns/1ns
module frt_prescale (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Control
   input wire logic run,
   input wire logic [1:0] src,
   // Tick enable
   output logic tick
);

   logic [2:0] div_q;
   logic [2:0] mask;

   always_comb begin
      case (src)
         frt_pkg::SRC_DIV2: mask = frt_pkg::MASK_DIV2;
         frt_pkg::SRC_DIV4: mask = frt_pkg::MASK_DIV4;
         default: mask = frt_pkg::MASK_DIV8;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_q <= 3'h0;
      end else if (run) begin
         div_q <= div_q + 3'h1;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tick <= 1'b0;
      end else begin
         tick <= run && ((div_q & mask) == mask);
      end
   end

endmodule : frt_prescale

/* hdl/frt_edge.sv */
`timescale 1ns/1ns
module frt_edge (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Pin and edge choice
   input wire logic pin,
   input wire logic rise_sel,
   // One-cycle event
   output logic pulse
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // s1_q feeds only s2_q
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pulse <= 1'b0;
      end else begin
         pulse <= rise_sel ? (s2_q & ~s3_q) : (~s2_q & s3_q);
      end
   end

endmodule : frt_edge

/* hdl/frt_timer.sv */
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ns
// Summary of operation
// - Sixteen-bit up-counter advances once per selected tick, read as two bytes.
// - Two views show the same count; shadow low read never clears rollover.
// - Writing either low byte reloads FFFC; FFFC is also reset value.
// - Tick source is CPU clock over 2, 4, 8 or external.
// - External tick only when both select bits set; edge bit picks transition.
// - External tick edges are synchronised to the CPU clock before counting.
// - Upper byte read latches low byte; latch holds until low byte access.
// - After a completed pair, lone low read returns the live low byte.
// - Counter wrap from FFFF to 0000 sets rollover flag in all modes.
// - Rollover request raised only with enable set and global mask clear.
// - Rollover flag clears after status read seeing it, then main low access.
// - Counting and capture carry on unchanged in WAIT.
// - HALT freezes the count; reset restarts it from reset value.
// - Capture edge copies counter into channel register and sets its flag.
// - Each capture channel has its own edge select bit.
// - One capture enable covers both channels, gated by global mask.
// - Capture flag clears after status read seeing it, then low byte access.
// - Upper capture read blocks new captures until low byte read.
// - In one-pulse or PWM mode only the second channel captures.
// - Capture pins are always connected; only the transition chosen by the edge bit captures.
// - Second instance lacks second capture channel; that channel's flag reads zero.
module frt_timer #(
   parameter bit HAS_CAP2 = 1'b1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic ext_tick_pin,
   input wire logic capture_pin_1,
   input wire logic capture_pin_2,
   // CPU state
   input wire logic irq_mask,
   input wire logic halt,
   // Requests
   output logic rollover_irq,
   output logic capture_irq
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] control_one_q;
   logic [7:0] control_two_q;
   logic [15:0] cnt_q;
   logic rollover_flag_q;
   logic roll_arm_q;
   logic [1:0] lat_q;
   logic [7:0] latv_q [2];
   logic [15:0] cap_q [2];
   logic [1:0] capture_flag_q;
   logic [1:0] cap_arm_q;
   logic [1:0] cap_inh_q;
   logic [1:0] cap_pulse;
   logic [1:0] cap_ev;
   logic [1:0] cap_pin;
   logic [1:0] edge_sel;
   logic [31:0] prdata_d;
   logic map_ok;
   logic done;
   logic rd_setup;
   logic rd_done;
   logic wr_done;
   logic int_tick;
   logic ext_pulse;
   logic tick;
   logic reload;
   logic wrap;
   logic ext_sel;
   logic wave_mode;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : hit

   function automatic logic [7:0] lo_off(input int v);
      return (v == 0) ? frt_pkg::OFF_CNT_LO : frt_pkg::OFF_SHD_LO;
   endfunction : lo_off

   function automatic logic [7:0] hi_off(input int v);
      return (v == 0) ? frt_pkg::OFF_CNT_HI : frt_pkg::OFF_SHD_HI;
   endfunction : hi_off

   function automatic logic [7:0] cap_lo_off(input int c);
      return (c == 0) ? frt_pkg::OFF_CAP1_LO : frt_pkg::OFF_CAP2_LO;
   endfunction : cap_lo_off

   function automatic logic [7:0] cap_hi_off(input int c);
      return (c == 0) ? frt_pkg::OFF_CAP1_HI : frt_pkg::OFF_CAP2_HI;
   endfunction : cap_hi_off

   // ----------------------------------------
   // APB handshake
   // ----------------------------------------
   // One wait-free access phase; data is sampled in the setup cycle
   assign done = psel & penable & pready;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign rd_done = done & ~pwrite;
   assign wr_done = done & pwrite;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable) begin
         pready <= 1'b1;
         pslverr <= ~map_ok;
         prdata <= pwrite ? 32'h0000_0000 : prdata_d;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_comb begin
      prdata_d = 32'h0000_0000;
      map_ok = 1'b1;
      case (paddr)
         frt_pkg::OFF_CTRL1: prdata_d[7:0] = control_one_q;
         frt_pkg::OFF_CTRL2: prdata_d[7:0] = control_two_q;
         frt_pkg::OFF_STATUS: begin
            prdata_d[frt_pkg::ST_ROLL] = rollover_flag_q;
            prdata_d[frt_pkg::ST_CAP1] = capture_flag_q[0];
            prdata_d[frt_pkg::ST_CAP2] = capture_flag_q[1];
         end
         frt_pkg::OFF_CNT_HI: prdata_d[7:0] = cnt_q[15:8];
         frt_pkg::OFF_CNT_LO: prdata_d[7:0] = lat_q[0] ? latv_q[0] : cnt_q[7:0];
         frt_pkg::OFF_SHD_HI: prdata_d[7:0] = cnt_q[15:8];
         frt_pkg::OFF_SHD_LO: prdata_d[7:0] = lat_q[1] ? latv_q[1] : cnt_q[7:0];
         frt_pkg::OFF_CAP1_HI: prdata_d[7:0] = cap_q[0][15:8];
         frt_pkg::OFF_CAP1_LO: prdata_d[7:0] = cap_q[0][7:0];
         frt_pkg::OFF_CAP2_HI: prdata_d[7:0] = cap_q[1][15:8];
         frt_pkg::OFF_CAP2_LO: prdata_d[7:0] = cap_q[1][7:0];
         default: map_ok = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         control_one_q <= frt_pkg::CTRL_RESET;
         control_two_q <= frt_pkg::CTRL_RESET;
      end else if (wr_done) begin
         if (hit(paddr, frt_pkg::OFF_CTRL1)) begin
            control_one_q <= pwdata[7:0];
         end
         if (hit(paddr, frt_pkg::OFF_CTRL2)) begin
            control_two_q <= pwdata[7:0];
         end
      end
   end

   assign wave_mode = control_two_q[frt_pkg::C2_OPM] | control_two_q[frt_pkg::C2_PWM];
   assign ext_sel = control_two_q[frt_pkg::C2_SRC +: 2] == frt_pkg::SRC_EXT;

   // ----------------------------------------
   // Tick generation
   // ----------------------------------------
   // No WAIT input: the timer simply ignores that state
   frt_prescale u_prescale (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .run(~halt & ~ext_sel),
      .src(control_two_q[frt_pkg::C2_SRC +: 2]),
      .tick(int_tick)
   );

   // Pin filtered through two flops before any edge logic
   frt_edge u_ext (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin(ext_tick_pin),
      .rise_sel(control_two_q[frt_pkg::C2_EXT_EDGE]),
      .pulse(ext_pulse)
   );

   // Tick is gated again here so a pipelined pulse cannot leak into HALT
   assign tick = ~halt & (ext_sel ? ext_pulse : int_tick);

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   assign reload = wr_done & (hit(paddr, frt_pkg::OFF_CNT_LO) | hit(paddr, frt_pkg::OFF_SHD_LO));
   assign wrap = tick & ~reload & (cnt_q == frt_pkg::CNT_TOP);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= frt_pkg::CNT_RESET;
      end else if (reload) begin
         cnt_q <= frt_pkg::CNT_RESET;
      end else if (tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // ----------------------------------------
   // Buffered read of both views
   // ----------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         lat_q <= 2'b00;
         latv_q[0] <= 8'h00;
         latv_q[1] <= 8'h00;
      end else begin
         for (int v = 0; v < 2; v++) begin
            // Latch where the upper byte is sampled, so a carry cannot split the pair
            if (rd_setup & hit(paddr, hi_off(v)) & ~lat_q[v]) begin
               lat_q[v] <= 1'b1;
               latv_q[v] <= cnt_q[7:0];
            end else if (done & hit(paddr, lo_off(v))) begin
               lat_q[v] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // Rollover flag
   // ----------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rollover_flag_q <= 1'b0;
         roll_arm_q <= 1'b0;
      end else begin
         if (wrap) begin
            rollover_flag_q <= 1'b1;
         end else if (roll_arm_q & done & hit(paddr, frt_pkg::OFF_CNT_LO)) begin
            rollover_flag_q <= 1'b0;
         end
         // Shadow low access never touches the arm, so it cannot clear
         if (rd_done & hit(paddr, frt_pkg::OFF_STATUS) & prdata[frt_pkg::ST_ROLL]) begin
            roll_arm_q <= 1'b1;
         end else if (done & hit(paddr, frt_pkg::OFF_CNT_LO)) begin
            roll_arm_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Capture channels
   // ----------------------------------------
   assign cap_pin = {capture_pin_2, capture_pin_1};
   assign edge_sel = {control_two_q[frt_pkg::C2_EDGE2], control_one_q[frt_pkg::C1_EDGE1]};

   for (genvar c = 0; c < 2; c++) begin : g_cap
      logic en;
      if (c == 0) begin : g_first
         assign en = ~wave_mode;
      end else begin : g_second
         assign en = HAS_CAP2;
      end

      frt_edge u_edge (
         .mclk(mclk),
         .sys_rst(sys_rst),
         .pin(cap_pin[c]),
         .rise_sel(edge_sel[c]),
         .pulse(cap_pulse[c])
      );

      assign cap_ev[c] = cap_pulse[c] & en & ~cap_inh_q[c];

      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            cap_q[c] <= 16'h0000;
         end else if (cap_ev[c]) begin
            cap_q[c] <= cnt_q;
         end
      end

      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            capture_flag_q[c] <= 1'b0;
            cap_arm_q[c] <= 1'b0;
         end else begin
            if (cap_ev[c]) begin
               capture_flag_q[c] <= 1'b1;
            end else if (cap_arm_q[c] & done & hit(paddr, cap_lo_off(c))) begin
               capture_flag_q[c] <= 1'b0;
            end
            if (rd_done & hit(paddr, frt_pkg::OFF_STATUS) & prdata[c]) begin
               cap_arm_q[c] <= 1'b1;
            end else if (done & hit(paddr, cap_lo_off(c))) begin
               cap_arm_q[c] <= 1'b0;
            end
         end
      end

      // Reading the upper byte also lets software mute a pin it toggles
      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            cap_inh_q[c] <= 1'b0;
         end else if (rd_done & hit(paddr, cap_hi_off(c))) begin
            cap_inh_q[c] <= 1'b1;
         end else if (rd_done & hit(paddr, cap_lo_off(c))) begin
            cap_inh_q[c] <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Interrupt requests
   // ----------------------------------------
   // Flags stay set while masked, so the request appears once unmasked
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rollover_irq <= 1'b0;
         capture_irq <= 1'b0;
      end else begin
         rollover_irq <= rollover_flag_q & control_one_q[frt_pkg::C1_ROLL_IE] & ~irq_mask;
         capture_irq <= (|capture_flag_q) & control_one_q[frt_pkg::C1_CAP_IE] & ~irq_mask;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence s_roll_armed;
      rd_done && hit(paddr, frt_pkg::OFF_STATUS) && prdata[frt_pkg::ST_ROLL];
   endsequence

   sequence s_cnt_lo_access;
      done && hit(paddr, frt_pkg::OFF_CNT_LO) && !wrap;
   endsequence

   sequence s_hi_read_fresh;
      rd_setup && hit(paddr, frt_pkg::OFF_CNT_HI) && !lat_q[0];
   endsequence

   reload_value_a: assert property (
      reload |=> cnt_q == 16'hFFFC
   ) else $error("counter not reloaded to FFFC");

   wrap_sets_a: assert property (
      tick && !reload && cnt_q == 16'hFFFF |=> rollover_flag_q && cnt_q == 16'h0000
   ) else $error("wrap did not set rollover flag");

   roll_clear_a: assert property (
      s_roll_armed ##1 (!done) [*2] ##1 s_cnt_lo_access |=> !rollover_flag_q
   ) else $error("rollover flag not cleared by two-step sequence");

   shadow_keep_a: assert property (
      done && hit(paddr, frt_pkg::OFF_SHD_LO) && rollover_flag_q |=> rollover_flag_q
   ) else $error("shadow low access cleared rollover flag");

   latch_hold_a: assert property (
      s_hi_read_fresh ##1 (!(done && hit(paddr, frt_pkg::OFF_CNT_LO))) [*3]
      |-> lat_q[0] && latv_q[0] == $past(cnt_q[7:0], 3)
   ) else $error("latched low byte did not hold");

   roll_irq_a: assert property (
      rollover_flag_q && control_one_q[frt_pkg::C1_ROLL_IE] && !irq_mask |=> rollover_irq
   ) else $error("rollover request missing");

   mask_gate_a: assert property (
      irq_mask |=> !rollover_irq && !capture_irq
   ) else $error("request raised while masked");

   halt_hold_a: assert property (
      halt && !reload |=> cnt_q == $past(cnt_q)
   ) else $error("counter moved during HALT");

   cap_take_a: assert property (
      cap_ev[1] |=> cap_q[1] == $past(cnt_q) && capture_flag_q[1]
   ) else $error("capture value or flag wrong");

   cap_block_a: assert property (
      cap_inh_q[0] |=> cap_q[0] == $past(cap_q[0]) && !$rose(capture_flag_q[0])
   ) else $error("capture taken while blocked");

   wave_cap1_a: assert property (
      wave_mode && cap_pulse[0] |=> cap_q[0] == $past(cap_q[0])
   ) else $error("first channel captured in wave mode");

   no_cap2_a: assert property (
      !HAS_CAP2 |-> capture_flag_q[1] == 1'b0
   ) else $error("absent channel flag set");

endmodule : frt_timer

/* bench/frt_pin_src.sv */
`timescale 1ns/1ns
module frt_pin_src (
   // Clock
   input wire logic mclk,
   // Pins
   output logic ext_tick_pin,
   output logic capture_pin_1,
   output logic capture_pin_2
);
   initial begin
      ext_tick_pin = 1'b0;
      capture_pin_1 = 1'b0;
      capture_pin_2 = 1'b0;
   end

   // Eight idle clocks after each change let the event land
   task automatic set_pin(input int ch, input logic v);
      @(posedge mclk);
      if (ch == 1) capture_pin_1 <= v;
      else if (ch == 2) capture_pin_2 <= v;
      else ext_tick_pin <= v;
      repeat (8) @(posedge mclk);
   endtask : set_pin

   task automatic ext_burst(input int n);
      for (int i = 0; i < n; i++) begin
         set_pin(0, 1'b1);
         set_pin(0, 1'b0);
      end
   endtask : ext_burst
endmodule : frt_pin_src

/* bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   logic mclk, sys_rst, psel, penable, pwrite, irq_mask, halt, perr, roll_irq, cap_irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, prdata_a, rd, rd_a;
   logic pready, pslverr, ext_tick_pin, capture_pin_1, capture_pin_2;
   logic [15:0] k;
   int err_count, num_checks;

   frt_timer dut (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_tick_pin(ext_tick_pin),
      .capture_pin_1(capture_pin_1), .capture_pin_2(capture_pin_2), .irq_mask(irq_mask),
      .halt(halt), .rollover_irq(roll_irq), .capture_irq(cap_irq));
   // Variant without channel two shares the bus; only its read data is used
   frt_timer #(.HAS_CAP2(1'b0)) dut_a (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata_a),
      .pready(), .pslverr(), .ext_tick_pin(ext_tick_pin), .capture_pin_1(capture_pin_1),
      .capture_pin_2(capture_pin_2), .irq_mask(irq_mask), .halt(halt), .rollover_irq(),
      .capture_irq());
   frt_pin_src src (.mclk(mclk), .ext_tick_pin(ext_tick_pin),
      .capture_pin_1(capture_pin_1), .capture_pin_2(capture_pin_2));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Request stands until pready is seen high at a rising edge; data taken there
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         close_out();
      end
      rd = prdata;
      rd_a = prdata_a;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask : rdchk

   task automatic rd16(input logic [7:0] hi, output logic [15:0] v);
      apb(1'b0, hi, 32'h0);
      v[15:8] = rd[7:0];
      apb(1'b0, hi + 8'h04, 32'h0);
      v[7:0] = rd[7:0];
   endtask : rd16

   task automatic run(input int n);
      @(posedge mclk);
      halt <= 1'b0;
      repeat (n) @(posedge mclk);
      halt <= 1'b1;
   endtask : run

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      irq_mask = 1'b0;
      halt = 1'b1;
      err_count = 0;
      num_checks = 0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      rdchk("ctrl1", frt_pkg::OFF_CTRL1, 32'h0);
      rdchk("ctrl2", frt_pkg::OFF_CTRL2, 32'h0);
      rdchk("count hi", frt_pkg::OFF_CNT_HI, 32'hFF);
      rdchk("count lo", frt_pkg::OFF_CNT_LO, 32'hFC);
      rdchk("unmapped", 8'h2C, 32'h0);
      chk("slverr", {31'h0, perr}, 32'h1);
      run(20);
      apb(1'b1, frt_pkg::OFF_SHD_LO, 32'h0);
      rdchk("count hi", frt_pkg::OFF_CNT_HI, 32'hFF);
      run(30);
      apb(1'b0, frt_pkg::OFF_CNT_HI, 32'h0);
      rdchk("latched lo", frt_pkg::OFF_CNT_LO, 32'hFC);
      rd16(frt_pkg::OFF_SHD_HI, k);
      rdchk("live lo", frt_pkg::OFF_CNT_LO, {24'h0, k[7:0]});
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, frt_pkg::OFF_CTRL2, 32'(s));
         apb(1'b1, frt_pkg::OFF_CNT_LO, 32'h0);
         run(64);
         rd16(frt_pkg::OFF_SHD_HI, k);
         k = k - 16'hFFFC;
         chk("ticks", {31'h0, k + 16'd1 >= (16'd32 >> s) && k <= (16'd32 >> s) + 16'd1},
            32'h1);
      end
      apb(1'b1, frt_pkg::OFF_CTRL2, 32'h07);
      apb(1'b1, frt_pkg::OFF_CNT_LO, 32'h0);
      @(posedge mclk);
      halt <= 1'b0;
      src.ext_burst(5);
      @(posedge mclk);
      halt <= 1'b1;
      rd16(frt_pkg::OFF_SHD_HI, k);
      chk("ext count", {16'h0, k}, 32'h0001);
      apb(1'b1, frt_pkg::OFF_CTRL2, 32'h03);
      apb(1'b1, frt_pkg::OFF_SHD_LO, 32'h0);
      @(posedge mclk);
      halt <= 1'b0;
      src.ext_burst(2);
      @(posedge mclk);
      halt <= 1'b1;
      rd16(frt_pkg::OFF_SHD_HI, k);
      chk("ext fall count", {16'h0, k}, 32'h0000_FFFE);
      apb(1'b1, frt_pkg::OFF_CTRL2, 32'h0);
      apb(1'b1, frt_pkg::OFF_CTRL1, 32'h02);
      apb(1'b0, frt_pkg::OFF_CNT_LO, 32'h0);
      rdchk("status", frt_pkg::OFF_STATUS, 32'h04);
      @(negedge mclk);
      chk("roll irq", {31'h0, roll_irq}, 32'h1);
      @(posedge mclk);
      irq_mask <= 1'b1;
      repeat (3) @(negedge mclk);
      chk("roll irq masked", {31'h0, roll_irq}, 32'h0);
      @(posedge mclk);
      irq_mask <= 1'b0;
      apb(1'b0, frt_pkg::OFF_SHD_LO, 32'h0);
      rdchk("status", frt_pkg::OFF_STATUS, 32'h04);
      apb(1'b0, frt_pkg::OFF_CNT_LO, 32'h0);
      rdchk("status", frt_pkg::OFF_STATUS, 32'h00);
      apb(1'b1, frt_pkg::OFF_CNT_LO, 32'h0);
      apb(1'b1, frt_pkg::OFF_CTRL1, 32'h05);
      src.set_pin(1, 1'b1);
      rdchk("status", frt_pkg::OFF_STATUS, 32'h01);
      @(negedge mclk);
      chk("cap irq", {31'h0, cap_irq}, 32'h1);
      rdchk("cap1 hi", frt_pkg::OFF_CAP1_HI, 32'hFF);
      run(4);
      src.set_pin(1, 1'b0);
      src.set_pin(1, 1'b1);
      rdchk("cap1 lo", frt_pkg::OFF_CAP1_LO, 32'hFC);
      rdchk("status", frt_pkg::OFF_STATUS, 32'h00);
      src.set_pin(1, 1'b0);
      src.set_pin(1, 1'b1);
      rd16(frt_pkg::OFF_SHD_HI, k);
      rdchk("status", frt_pkg::OFF_STATUS, 32'h01);
      rdchk("cap1 hi", frt_pkg::OFF_CAP1_HI, {24'h0, k[15:8]});
      rdchk("cap1 lo", frt_pkg::OFF_CAP1_LO, {24'h0, k[7:0]});
      src.set_pin(2, 1'b1);
      rdchk("status", frt_pkg::OFF_STATUS, 32'h00);
      src.set_pin(2, 1'b0);
      rdchk("status", frt_pkg::OFF_STATUS, 32'h02);
      chk("variant status", rd_a, 32'h00);
      apb(1'b1, frt_pkg::OFF_CTRL2, 32'h10);
      src.set_pin(1, 1'b0);
      src.set_pin(1, 1'b1);
      rdchk("status", frt_pkg::OFF_STATUS, 32'h02);
      apb(1'b1, frt_pkg::OFF_CTRL2, 32'h20);
      src.set_pin(1, 1'b0);
      src.set_pin(1, 1'b1);
      rdchk("status", frt_pkg::OFF_STATUS, 32'h02);
      @(posedge mclk);
      irq_mask <= 1'b1;
      repeat (3) @(negedge mclk);
      chk("cap irq masked", {31'h0, cap_irq}, 32'h0);
      close_out();
   end
endmodule : tb_top
